//--- qbs_defines.svh
`ifndef QBS_DEFINES_SVH
`define QBS_DEFINES_SVH

// ----------------------------------------
// array geometry
// ----------------------------------------
`define QBS_DW        36
`define QBS_AW        17
`define QBS_LANE_W    9
`define QBS_BEATS     4

// ----------------------------------------
// controller timing
// ----------------------------------------
`define QBS_CLK_MHZ   40
`define QBS_SETUP_US  20
`define QBS_SETUP_CYC (`QBS_SETUP_US * `QBS_CLK_MHZ)
`define QBS_WR_FIRST  2
`define QBS_WR_LAST   5
`define QBS_RD_FIRST  7
`define QBS_RD_LAST   10
`define QBS_CNT_W     4

`endif

//--- qbs_if.sv
`timescale 1ns/1ps
`include "qbs_defines.svh"

interface qbs_if #(
  parameter int DW    = `QBS_DW,
  parameter int AW    = `QBS_AW,
  parameter int LANES = `QBS_DW / `QBS_LANE_W
);
  logic             k;
  logic             k_n;
  logic             c;
  logic             c_n;
  logic             rd_req_n;
  logic             wr_req_n;
  logic [AW-1:0]    addr;
  logic [DW-1:0]    d;
  logic [LANES-1:0] lane_store_enable_n;
  logic             loop_bypass_n;
  logic [DW-1:0]    q;
  logic             q_oe;
  logic             returned_timing_pos;
  logic             returned_timing_neg;

  modport dev (
    input  k, k_n, c, c_n, rd_req_n, wr_req_n, addr, d,
    input  lane_store_enable_n, loop_bypass_n,
    output q, q_oe, returned_timing_pos, returned_timing_neg
  );

  modport ctl (
    output k, k_n, c, c_n, rd_req_n, wr_req_n, addr, d,
    output lane_store_enable_n, loop_bypass_n,
    input  q, q_oe, returned_timing_pos, returned_timing_neg
  );
endinterface : qbs_if

//--- qbs_link_props.sv
`timescale 1ns/1ps

module qbs_link_props #(
  parameter int SETUP_CYC = 8
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic k,
  input wire logic k_n,
  input wire logic c,
  input wire logic c_n,
  input wire logic rd_req_n,
  input wire logic wr_req_n,
  input wire logic loop_bypass_n,
  input wire logic q_oe,
  input wire logic returned_timing_pos,
  input wire logic returned_timing_neg
);
  // ----------------------------------------
  // helper logic and checks
  // ----------------------------------------
  int   setup_cnt_q;
  logic rd_take;
  logic wr_take;

  assign rd_take = !k && !rd_req_n;
  assign wr_take = !k && !wr_req_n && rd_req_n;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      setup_cnt_q <= 0;
    end else if (setup_cnt_q < SETUP_CYC) begin
      setup_cnt_q <= setup_cnt_q + 1;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  AST_PWRUP_HIZ: assert property (setup_cnt_q < SETUP_CYC |-> !q_oe)
    else $error("read outputs driven during setup");
  AST_SETUP_NOP: assert property (setup_cnt_q < SETUP_CYC |-> rd_req_n && wr_req_n)
    else $error("request issued during setup");
  AST_RD_BURST: assert property (rd_take |-> ##[3:5] $rose(q_oe))
    else $error("read burst not launched");
  AST_OE_LEN: assert property ($rose(q_oe) |-> q_oe [*4] ##1 !q_oe)
    else $error("read burst not four beats");
  AST_OE_CAUSE: assert property ($rose(q_oe) |->
    $past(rd_take, 3) || $past(rd_take, 4) || $past(rd_take, 5))
    else $error("outputs driven without read");
  AST_WR_NO_OE: assert property (wr_take |-> !q_oe [*6])
    else $error("outputs driven during write");
  AST_REQ_ONE: assert property ($fell(rd_req_n) || $fell(wr_req_n) |->
    ##[1:2] (rd_req_n && wr_req_n))
    else $error("request not returned high");
  AST_NO_DUAL: assert property (rd_req_n || wr_req_n)
    else $error("read and write requested together");
  AST_SAME_GAP: assert property ($rose(rd_req_n) |-> rd_req_n [*3])
    else $error("reads on consecutive edges");
  AST_K_PAIR: assert property (k_n != k && c && c_n && !loop_bypass_n)
    else $error("clock pair or bypass level wrong");
  AST_ECHO: assert property (setup_cnt_q >= 2 |->
    $changed(returned_timing_pos) && returned_timing_pos != returned_timing_neg)
    else $error("echo clock not running");

  COV_RD: cover property (rd_take ##4 q_oe);
  COV_WR: cover property (wr_take);
  COV_RD_AFTER_WR: cover property (wr_take ##[1:20] rd_take);
endmodule : qbs_link_props

//--- qbs_pkg.sv
package qbs_pkg;

  // ----------------------------------------
  // controller sequencing
  // ----------------------------------------
  typedef enum logic [1:0] {
    QBS_SETUP,
    QBS_IDLE,
    QBS_WRITE,
    QBS_READ
  } qbs_state_e;

endpackage : qbs_pkg

//--- qbs_sram_ctl.sv
`timescale 1ns/1ps
`include "qbs_defines.svh"

module qbs_sram_ctl #(
  parameter int DW        = `QBS_DW,
  parameter int AW        = `QBS_AW,
  parameter int LANES     = `QBS_DW / `QBS_LANE_W,
  parameter int SETUP_CYC = `QBS_SETUP_CYC
) (
  input  wire logic                     CLK_SYS,
  input  wire logic                     RST,
  input  wire logic                     REQ_VALID,
  input  wire logic                     REQ_WRITE,
  input  wire logic [AW-1:0]            REQ_ADDR,
  input  wire logic [4*DW-1:0]          REQ_WDATA,
  input  wire logic [4*LANES-1:0]       REQ_MASK_N,
  output logic                          REQ_READY,
  output logic                          RD_VALID,
  output logic [4*DW-1:0]               RD_DATA,
  output logic                          SETUP_DONE,
  qbs_if.ctl                            BUS
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  qbs_pkg::qbs_state_e   st_q;
  logic                  k_q;
  logic [`QBS_CNT_W-1:0] cnt_q;
  logic [15:0]           setup_q;
  logic [4*DW-1:0]       wdata_q;
  logic [4*LANES-1:0]    mask_q;
  logic                  rd_n_q;
  logic                  wr_n_q;
  logic [AW-1:0]         addr_q;
  logic [DW-1:0]         d_q;
  logic [LANES-1:0]      be_q;
  logic [DW-1:0]         qs1_q;
  logic [DW-1:0]         qs2_q;
  logic                  take;
  logic                  rd_pin_q;
  logic                  wr_pin_q;
  logic [AW-1:0]         addr_pin_q;
  logic [DW-1:0]         d_pin_q;
  logic [LANES-1:0]      be_pin_q;

  // ----------------------------------------
  // link clocks and static pins
  // ----------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      k_q <= 1'b0;
    end else begin
      k_q <= ~k_q;
    end
  end

  assign BUS.k                   = k_q;
  assign BUS.k_n                 = ~k_q;
  assign BUS.c                   = 1'b1;
  assign BUS.c_n                 = 1'b1;
  assign BUS.loop_bypass_n       = 1'b0;
  assign BUS.rd_req_n            = rd_pin_q;
  assign BUS.wr_req_n            = wr_pin_q;
  assign BUS.addr                = addr_pin_q;
  assign BUS.d                   = d_pin_q;
  assign BUS.lane_store_enable_n = be_pin_q;

  assign REQ_READY  = (st_q == qbs_pkg::QBS_IDLE) && k_q;
  assign take       = REQ_VALID && REQ_READY;
  assign SETUP_DONE = (st_q != qbs_pkg::QBS_SETUP);

  // ----------------------------------------
  // pin launch on the falling edge
  // ----------------------------------------
  // k rises on a rising edge; pins move half a cycle away from it
  always_ff @(negedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rd_pin_q   <= 1'b1;
      wr_pin_q   <= 1'b1;
      addr_pin_q <= '0;
      d_pin_q    <= '0;
      be_pin_q   <= '1;
    end else begin
      rd_pin_q   <= rd_n_q;
      wr_pin_q   <= wr_n_q;
      addr_pin_q <= addr_q;
      d_pin_q    <= d_q;
      be_pin_q   <= be_q;
    end
  end

  // ----------------------------------------
  // read data capture
  // ----------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      qs1_q <= '0;
      qs2_q <= '0;
    end else begin
      qs1_q <= BUS.q;
      qs2_q <= qs1_q;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      st_q     <= qbs_pkg::QBS_SETUP;
      setup_q  <= '0;
      cnt_q    <= '0;
      rd_n_q   <= 1'b1;
      wr_n_q   <= 1'b1;
      addr_q   <= '0;
      d_q      <= '0;
      be_q     <= '1;
      wdata_q  <= '0;
      mask_q   <= '1;
      RD_DATA  <= '0;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= 1'b0;
      cnt_q    <= cnt_q + 1'b1;
      unique case (st_q)
        qbs_pkg::QBS_SETUP: begin
          setup_q <= setup_q + 1'b1;
          if (setup_q == 16'(SETUP_CYC - 1)) begin
            st_q <= qbs_pkg::QBS_IDLE;
          end
        end
        qbs_pkg::QBS_IDLE: begin
          if (take) begin
            cnt_q   <= `QBS_CNT_W'(1);
            addr_q  <= REQ_ADDR;
            wdata_q <= REQ_WDATA;
            mask_q  <= REQ_MASK_N;
            if (REQ_WRITE) begin
              wr_n_q <= 1'b0;
              st_q   <= qbs_pkg::QBS_WRITE;
            end else begin
              rd_n_q <= 1'b0;
              st_q   <= qbs_pkg::QBS_READ;
            end
          end
        end
        qbs_pkg::QBS_WRITE: begin
          wr_n_q <= 1'b1;
          if (cnt_q >= `QBS_CNT_W'(`QBS_WR_FIRST)) begin
            d_q  <= wdata_q[(cnt_q - `QBS_WR_FIRST)*DW +: DW];
            be_q <= mask_q[(cnt_q - `QBS_WR_FIRST)*LANES +: LANES];
          end
          if (cnt_q == `QBS_CNT_W'(`QBS_WR_LAST)) begin
            st_q <= qbs_pkg::QBS_IDLE;
          end
        end
        qbs_pkg::QBS_READ: begin
          rd_n_q <= 1'b1;
          if (cnt_q >= `QBS_CNT_W'(`QBS_RD_FIRST)) begin
            RD_DATA[(cnt_q - `QBS_RD_FIRST)*DW +: DW] <= qs2_q;
          end
          if (cnt_q == `QBS_CNT_W'(`QBS_RD_LAST)) begin
            RD_VALID <= 1'b1;
            st_q     <= qbs_pkg::QBS_IDLE;
          end
        end
      endcase
    end
  end

endmodule : qbs_sram_ctl

//--- qbs_sram_dev.sv
`timescale 1ns/1ps
`include "qbs_defines.svh"
// Summary of operation
// - write low, read high starts four-beat write
// - read low starts four output beats
// - data in both phases; output clock selectable
// - requests sampled on main true edge
// - read outputs high impedance through power-up
// - park stopped clocks in opposite polarity
// - request ignored cycle after it initiated
// - consecutive same requests: second one dropped
// - wide variant: four nine-bit lane enables
// - narrow variant: two lanes, per-beat sampling
// - two internal address bits count 0..3
// - simultaneous requests: read wins
// - single-clock mode: bypass high, 20 us clocks
// - double-clock mode: bypass high, 20 us clocks
// - bypass low: 20 us no-operation setup
// - loop unusable below 120 MHz; bypass
// - redo setup after frequency or bypass change
// - bypass input low bypasses the loop
// - echo clocks run freely with data

module qbs_sram_dev #(
  parameter int DW    = `QBS_DW,
  parameter int AW    = `QBS_AW,
  parameter int LW    = `QBS_LANE_W,
  parameter int LANES = DW / LW
) (
  input  wire logic CLK_SYS,
  input  wire logic RST,
  output logic      LOOP_BYPASSED,
  output logic      WRITE_DONE,
  output logic      READ_DONE,
  qbs_if.dev        BUS
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic                oc_sel;
  logic                oclk_p;
  logic                oclk_n;
  logic                rd_take;
  logic                wr_take;
  logic                rd_took_q;
  logic                wr_took_q;
  logic [3:1]          wv_q;
  logic [AW-1:0]       wa_q [1:3];
  logic [3:1]          rv_q;
  logic [4*DW-1:0]     rb_q [1:3];
  logic [DW-1:0]       dp_q;
  logic [DW-1:0]       dn_q;
  logic [LANES-1:0]    mp_q;
  logic [LANES-1:0]    mn_q;
  logic [DW-1:0]       qp_q;
  logic [DW-1:0]       qn_q;
  logic                oep_q;
  logic                oen_q;
  logic [DW-1:0]       mem_q [0:(2**(AW+2))-1];
  logic                wr_tgl_q;
  logic                rd_tgl_q;
  logic [2:0]          wr_s_q;
  logic [2:0]          rd_s_q;
  logic [1:0]          lb_s_q;

  function automatic logic [DW-1:0] lane_merge(
    input logic [DW-1:0]    old_w,
    input logic [DW-1:0]    new_w,
    input logic [LANES-1:0] en_n
  );
    logic [DW-1:0] res;
    res = old_w;
    for (int l = 0; l < LANES; l++) begin
      if (!en_n[l]) begin
        res[l*LW +: LW] = new_w[l*LW +: LW];
      end
    end
    return res;
  endfunction : lane_merge

  // ----------------------------------------
  // output clock selection and echo clocks
  // ----------------------------------------
  assign oc_sel                  = BUS.c & BUS.c_n;
  assign oclk_p                  = oc_sel ? BUS.k : BUS.c;
  assign oclk_n                  = oc_sel ? BUS.k_n : BUS.c_n;
  assign BUS.returned_timing_pos = oclk_p;
  assign BUS.returned_timing_neg = oclk_n;

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  always_comb begin
    rd_take = !BUS.rd_req_n && !rd_took_q;
    wr_take = !BUS.wr_req_n && !wr_took_q && !rd_take;
  end

  always_ff @(posedge BUS.k or posedge RST) begin
    if (RST) begin
      rd_took_q <= 1'b0;
      wr_took_q <= 1'b0;
    end else begin
      rd_took_q <= rd_take;
      wr_took_q <= wr_take;
    end
  end

  // ----------------------------------------
  // write data capture on both phases
  // ----------------------------------------
  always_ff @(posedge BUS.k or posedge RST) begin
    if (RST) begin
      dp_q <= '0;
      mp_q <= '1;
    end else begin
      dp_q <= BUS.d;
      mp_q <= BUS.lane_store_enable_n;
    end
  end

  always_ff @(posedge BUS.k_n or posedge RST) begin
    if (RST) begin
      dn_q <= '0;
      mn_q <= '1;
    end else begin
      dn_q <= BUS.d;
      mn_q <= BUS.lane_store_enable_n;
    end
  end

  // ----------------------------------------
  // burst pipelines
  // ----------------------------------------
  always_ff @(posedge BUS.k or posedge RST) begin
    if (RST) begin
      wv_q <= '0;
      rv_q <= '0;
      for (int i = 1; i <= 3; i++) begin
        wa_q[i] <= '0;
        rb_q[i] <= '0;
      end
    end else begin
      wv_q     <= {wv_q[2:1], wr_take};
      rv_q     <= {rv_q[2:1], rd_take};
      wa_q[2]  <= wa_q[1];
      wa_q[3]  <= wa_q[2];
      rb_q[2]  <= rb_q[1];
      rb_q[3]  <= rb_q[2];
      if (wr_take) begin
        wa_q[1] <= BUS.addr;
      end
      if (rd_take) begin
        rb_q[1] <= {mem_q[{BUS.addr, 2'h3}], mem_q[{BUS.addr, 2'h2}],
                    mem_q[{BUS.addr, 2'h1}], mem_q[{BUS.addr, 2'h0}]};
      end
    end
  end

  // ----------------------------------------
  // array update
  // ----------------------------------------
  always_ff @(posedge BUS.k) begin
    if (wv_q[2]) begin
      mem_q[{wa_q[2], 2'h0}] <= lane_merge(mem_q[{wa_q[2], 2'h0}], dp_q, mp_q);
      mem_q[{wa_q[2], 2'h1}] <= lane_merge(mem_q[{wa_q[2], 2'h1}], dn_q, mn_q);
    end
    if (wv_q[3]) begin
      mem_q[{wa_q[3], 2'h2}] <= lane_merge(mem_q[{wa_q[3], 2'h2}], dp_q, mp_q);
      mem_q[{wa_q[3], 2'h3}] <= lane_merge(mem_q[{wa_q[3], 2'h3}], dn_q, mn_q);
    end
  end

  // ----------------------------------------
  // read launch, complement phase
  // ----------------------------------------
  always_ff @(posedge oclk_n or posedge RST) begin
    if (RST) begin
      qn_q  <= '0;
      oen_q <= 1'b0;
    end else if (rv_q[2]) begin
      qn_q  <= rb_q[2][0 +: DW];
      oen_q <= 1'b1;
    end else if (rv_q[3]) begin
      qn_q  <= rb_q[3][2*DW +: DW];
      oen_q <= 1'b1;
    end else begin
      oen_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // read launch, true phase
  // ----------------------------------------
  always_ff @(posedge oclk_p or posedge RST) begin
    if (RST) begin
      qp_q  <= '0;
      oep_q <= 1'b0;
    end else if (rv_q[2]) begin
      qp_q  <= rb_q[2][DW +: DW];
      oep_q <= 1'b1;
    end else if (rv_q[3]) begin
      qp_q  <= rb_q[3][3*DW +: DW];
      oep_q <= 1'b1;
    end else begin
      oep_q <= 1'b0;
    end
  end

  assign BUS.q    = oclk_p ? qp_q : qn_q;
  assign BUS.q_oe = oclk_p ? oep_q : oen_q;

  // ----------------------------------------
  // burst completion events
  // ----------------------------------------
  always_ff @(posedge BUS.k or posedge RST) begin
    if (RST) begin
      wr_tgl_q <= 1'b0;
      rd_tgl_q <= 1'b0;
    end else begin
      wr_tgl_q <= wr_tgl_q ^ wv_q[3];
      rd_tgl_q <= rd_tgl_q ^ rv_q[3];
    end
  end

  // ----------------------------------------
  // system clock side
  // ----------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      wr_s_q <= '0;
      rd_s_q <= '0;
      lb_s_q <= '0;
    end else begin
      wr_s_q <= {wr_s_q[1:0], wr_tgl_q};
      rd_s_q <= {rd_s_q[1:0], rd_tgl_q};
      lb_s_q <= {lb_s_q[0], !BUS.loop_bypass_n};
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      WRITE_DONE    <= 1'b0;
      READ_DONE     <= 1'b0;
      LOOP_BYPASSED <= 1'b0;
    end else begin
      WRITE_DONE    <= wr_s_q[1] ^ wr_s_q[2];
      READ_DONE     <= rd_s_q[1] ^ rd_s_q[2];
      LOOP_BYPASSED <= lb_s_q[1];
    end
  end

endmodule : qbs_sram_dev

//--- tb_quad_rate_burst4_sram_port.sv
`timescale 1ns/1ps
`include "qbs_defines.svh"

module tb_quad_rate_burst4_sram_port;
  localparam int DW = 36;
  localparam int AW = 6;
  localparam int LN = 4;
  localparam int SC = 8;
  logic              CLK_SYS = 1'b0;
  logic              RST = 1'b1;
  logic              req_valid = 1'b0;
  logic              req_write = 1'b0;
  logic [AW-1:0]     req_addr = '0;
  logic [4*DW-1:0]   req_wdata = '0;
  logic [4*LN-1:0]   req_mask_n = '1;
  logic              req_ready, rd_valid, setup_done, loop_bypassed, wr_done, rd_done;
  logic [4*DW-1:0]   rd_data;
  logic [DW-1:0]     mem [int];
  int                num_errors = 0;
  int                compares = 0;
  int                nwr = 0;
  int                nrd = 0;
  int                wd_cnt = 0;
  int                rd_cnt = 0;

  qbs_if #(.DW(DW), .AW(AW), .LANES(LN)) bus ();

  qbs_sram_ctl #(.DW(DW), .AW(AW), .LANES(LN), .SETUP_CYC(SC)) i_qbs_sram_ctl (
    .CLK_SYS(CLK_SYS), .RST(RST), .REQ_VALID(req_valid), .REQ_WRITE(req_write),
    .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .REQ_MASK_N(req_mask_n),
    .REQ_READY(req_ready), .RD_VALID(rd_valid), .RD_DATA(rd_data),
    .SETUP_DONE(setup_done), .BUS(bus.ctl));

  qbs_sram_dev #(.DW(DW), .AW(AW), .LW(9), .LANES(LN)) i_qbs_sram_dev (
    .CLK_SYS(CLK_SYS), .RST(RST), .LOOP_BYPASSED(loop_bypassed),
    .WRITE_DONE(wr_done), .READ_DONE(rd_done), .BUS(bus.dev));

  qbs_link_props #(.SETUP_CYC(SC)) i_qbs_link_props (
    .CLK_SYS(CLK_SYS), .RST(RST), .k(bus.k), .k_n(bus.k_n), .c(bus.c), .c_n(bus.c_n),
    .rd_req_n(bus.rd_req_n), .wr_req_n(bus.wr_req_n), .loop_bypass_n(bus.loop_bypass_n),
    .q_oe(bus.q_oe), .returned_timing_pos(bus.returned_timing_pos),
    .returned_timing_neg(bus.returned_timing_neg));

  always #12.5 CLK_SYS = ~CLK_SYS;

  always @(posedge CLK_SYS) begin
    if (wr_done === 1'b1) wd_cnt++;
    if (rd_done === 1'b1) rd_cnt++;
  end

  // ----------------------------------------
  // checking and transfer tasks
  // ----------------------------------------
  task end_of_test;
    $display("counts: compares=%0d errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  task chk_data(input string nm, input logic [4*DW-1:0] e, input logic [4*DW-1:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_data

  task chk_num(input string nm, input int e, input int g);
    compares++;
    if (g != e) begin
      num_errors++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_num

  task wait_flag(input int which);
    int i;
    for (i = 0; i < 200; i++) begin
      @(negedge CLK_SYS);
      if ((which == 0 && req_ready === 1'b1) || (which == 1 && rd_valid === 1'b1)) break;
      if (which == 2 && wd_cnt >= nwr) break;
    end
    if (i == 200) begin
      num_errors++;
      $display("mismatch wait expected handshake seen none");
      end_of_test();
    end
  endtask : wait_flag

  task do_write(input logic [AW-1:0] a, input logic [4*DW-1:0] wd, input logic [4*LN-1:0] m);
    int b;
    int l;
    @(posedge CLK_SYS);
    req_write  <= 1'b1;
    req_addr   <= a;
    req_wdata  <= wd;
    req_mask_n <= m;
    req_valid  <= 1'b1;
    wait_flag(0);
    @(posedge CLK_SYS);
    req_valid <= 1'b0;
    for (b = 0; b < 4; b++)
      for (l = 0; l < LN; l++)
        if (!m[b*LN+l]) mem[a*4+b][l*9+:9] = wd[b*DW+l*9+:9];
    nwr++;
    wait_flag(2);
  endtask : do_write

  task do_read(input logic [AW-1:0] a);
    logic [4*DW-1:0] e;
    int b;
    @(posedge CLK_SYS);
    req_write <= 1'b0;
    req_addr  <= a;
    req_valid <= 1'b1;
    wait_flag(0);
    @(posedge CLK_SYS);
    req_valid <= 1'b0;
    for (b = 0; b < 4; b++) e[b*DW+:DW] = mem[a*4+b];
    wait_flag(1);
    chk_data("rd_data", e, rd_data);
    nrd++;
  endtask : do_read

  function automatic logic [4*DW-1:0] rnd_word();
    logic [159:0] r;
    r = {$urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
    return r[4*DW-1:0];
  endfunction : rnd_word

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int i;
    int l;
    logic [4*LN-1:0] m;
    void'($urandom(32'h2b2d));
    repeat (4) @(posedge CLK_SYS);
    RST <= 1'b0;
    for (i = 0; i < 8; i++) do_write(i[AW-1:0], rnd_word(), '0);
    for (i = 0; i < 8; i++) do_read(i[AW-1:0]);
    $display("test full bursts done");
    for (l = 0; l <= LN; l++) begin
      m = (l == LN) ? '1 : {4{~(4'b0001 << l)}};
      do_write(l[AW-1:0], rnd_word(), m);
      do_read(l[AW-1:0]);
    end
    $display("test lane enables done");
    for (i = 0; i < 20; i++) begin
      l = $urandom_range(7);
      do_write(l[AW-1:0], rnd_word(), 16'($urandom()));
      do_read(l[AW-1:0]);
    end
    $display("test per-beat masks done");
    repeat (8) @(posedge CLK_SYS);
    chk_data("loop_bypassed", 144'h1, {143'h0, loop_bypassed});
    chk_num("write_done", nwr, wd_cnt);
    chk_num("read_done", nrd, rd_cnt);
    $display("test status done");
    @(posedge CLK_SYS);
    RST <= 1'b1;
    repeat (4) @(posedge CLK_SYS);
    chk_data("q_oe", 144'h0, {143'h0, bus.q_oe});
    chk_data("setup_done", 144'h0, {143'h0, setup_done});
    RST <= 1'b0;
    do_read(6'h3);
    $display("test second reset done");
    end_of_test();
  end
endmodule : tb_quad_rate_burst4_sram_port
